// ### rtl/modbus_slave.v
// Query checker and read handler for a serial slave in a motor driver.
// Assumes a UART in the same clock domain that delivers bytes and an end-of-frame pulse,
// a holding register store answering one cycle after a read strobe.
//
// Notes on behaviour
// - Unsupported function code answers exception 01h.
// - Diagnosis with sub-function other than 0000h answers exception 01h.
// - Start address above 1FFFh answers 02h and records error 88h.
// - Start address plus count reaching 2000h answers 02h.
// - Count of zero or above 17 answers 03h and records error 8Ch.
// - Byte count not twice the register count answers 03h.
// - Frame length wrong for its function answers 03h.
// - User port busy answers 04h and records error 89h.
// - Internal busy or memory alarm answers 04h and records error 8Ah.
// - Write value out of setting range answers 04h, records 8Ch.
// - Read function returns one to sixteen registers from the start address.
// - Registers are fetched and sent in ascending address order.
// - Read reply echoes address, function, byte count, registers high first, check.
// - Exception reply carries function plus 80h, exception code, then check.
// - Frame check presets FFFFh, xors bytes, shifts, xors A001h on carry.
// - Broadcast queries are executed but never answered.
// - Error, bad check or over 256 bytes discards the query silently.
`include "modbus_consts.vh"

module modbus_slave (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire [7:0] slave_addr,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_err,
  input wire rx_end,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  output wire reg_rd_en,
  output wire [15:0] reg_rd_addr,
  input wire [15:0] reg_rd_data,
  output wire wr_en,
  output wire [15:0] wr_addr,
  output wire [15:0] wr_data,
  input wire wr_in_range,
  input wire ui_busy,
  input wire internal_processing_busy,
  input wire nvm_alarm,
  output wire [7:0] comm_err_code,
  output wire comm_err_pulse
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_CHECK = 3'd1;
  localparam [2:0] S_HDR = 3'd2;
  localparam [2:0] S_FETCH = 3'd3;
  localparam [2:0] S_LATCH = 3'd4;
  localparam [2:0] S_DATA = 3'd5;
  localparam [2:0] S_CRC = 3'd6;
  reg [2:0] state_q, idx_q, hdr_len_q;
  reg [7:0] q_mem [0:7];
  reg [8:0] len_q;
  reg [15:0] rx_crc_q, tx_crc_q, rd_addr_q, word_q;
  reg [7:0] tx_data_q, exc_q, cerr_q;
  reg [4:0] left_q;
  reg err_q, tx_valid_q, is_read_q, half_q, wr_en_q, cerr_pulse_q;
  reg [7:0] ld_byte;
  reg ld_go;
  wire [15:0] rx_crc_next;
  wire [15:0] tx_crc_next;
  wire [7:0] fc = q_mem[1];
  wire [15:0] start = {q_mem[2], q_mem[3]};
  wire [15:0] count = {q_mem[4], q_mem[5]};
  wire [16:0] span = {1'b0, start} + {1'b0, count};
  wire ranged = (fc == `FC_READ) || (fc == `FC_WRITE_MULTI);
  wire fire = tx_valid_q && tx_ready;
  // Function-dependent frame length
  function [8:0] want_len;
    input [7:0] f;
    input [15:0] n;
    begin
      if (f == `FC_WRITE_MULTI) begin
        want_len = `MULTI_BASE_LEN + {n[7:0], 1'b0};
      end else begin
        want_len = `FIXED_LEN;
      end
    end
  endfunction

  // ==========================================================
  // Frame check instances
  crc16_step rx_crc_u (.crc_in(rx_crc_q), .data_in(rx_data), .crc_out(rx_crc_next));
  crc16_step tx_crc_u (.crc_in(tx_crc_q), .data_in(ld_byte), .crc_out(tx_crc_next));

  // ==========================================================
  // Query validation
  reg discard;
  reg [7:0] exc;
  reg [7:0] cerr;
  always @* begin
    discard = err_q || (len_q > `FRAME_MAX) || (len_q < `FRAME_MIN) || (rx_crc_q != 16'h0000)
      || ((q_mem[0] != slave_addr) && (q_mem[0] != `BCAST_ADDR));
    exc = `EXC_NONE;
    cerr = `CERR_NONE;
    if ((fc != `FC_READ) && (fc != `FC_WRITE) && (fc != `FC_DIAG)
      && (fc != `FC_WRITE_MULTI)) begin
      exc = `EXC_FUNC;
    end else if ((fc == `FC_DIAG) && (start != 16'h0000)) begin
      exc = `EXC_FUNC;
    end else if ((fc != `FC_DIAG)
      && ((start > `ADDR_MAX) || (ranged && (span >= `ADDR_LIMIT)))) begin
      exc = `EXC_ADDR;
      cerr = `CERR_ADDR;
    end else if ((ranged && ((count == 16'h0000) || (count > `CNT_MAX)))
      || ((fc == `FC_WRITE_MULTI) && ({1'b0, count} + {1'b0, count} != {9'h000, q_mem[6]}))
      || (len_q != want_len(fc, count)) || ((fc == `FC_READ) && (count > `RD_MAX))) begin
      exc = `EXC_DATA;
      cerr = `CERR_RANGE;
    end else if (ui_busy) begin
      exc = `EXC_SLAVE;
      cerr = `CERR_UI_BUSY;
    end else if (internal_processing_busy || nvm_alarm) begin
      exc = `EXC_SLAVE;
      cerr = `CERR_NVM_BUSY;
    end else if ((fc == `FC_WRITE) && !wr_in_range) begin
      exc = `EXC_SLAVE;
      cerr = `CERR_RANGE;
    end
  end

  // ==========================================================
  // Reply byte selection
  always @* begin
    ld_go = !tx_valid_q && ((state_q == S_HDR) || (state_q == S_DATA) || (state_q == S_CRC));
    case (state_q)
      S_HDR: begin
        case (idx_q)
          3'd0: ld_byte = q_mem[0];
          3'd1: ld_byte = (exc_q != `EXC_NONE) ? (q_mem[1] | `EXC_FLAG) : q_mem[1];
          3'd2: ld_byte = (exc_q != `EXC_NONE) ? exc_q
            : (is_read_q ? {2'b00, left_q, 1'b0} : q_mem[2]);
          3'd3: ld_byte = q_mem[3];
          3'd4: ld_byte = q_mem[4];
          default: ld_byte = q_mem[5];
        endcase
      end
      S_DATA: ld_byte = half_q ? word_q[7:0] : word_q[15:8];
      S_CRC: ld_byte = half_q ? tx_crc_q[15:8] : tx_crc_q[7:0];
      default: ld_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Receive, check and reply sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      len_q <= 9'h000;
      err_q <= 1'b0;
      rx_crc_q <= `CRC_INIT;
      tx_crc_q <= `CRC_INIT;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      idx_q <= 3'd0;
      hdr_len_q <= 3'd0;
      exc_q <= `EXC_NONE;
      is_read_q <= 1'b0;
      rd_addr_q <= 16'h0000;
      left_q <= 5'd0;
      word_q <= 16'h0000;
      half_q <= 1'b0;
      wr_en_q <= 1'b0;
      cerr_q <= `CERR_NONE;
      cerr_pulse_q <= 1'b0;
    end else if (ce) begin
      wr_en_q <= 1'b0;
      cerr_pulse_q <= 1'b0;
      if (ld_go) begin
        tx_data_q <= ld_byte;
        tx_valid_q <= 1'b1;
        tx_crc_q <= (state_q == S_CRC) ? tx_crc_q : tx_crc_next; // Check bytes stay out of the sum
      end else if (fire) begin
        tx_valid_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (rx_valid) begin
            if (len_q < `FIXED_LEN) begin
              q_mem[len_q[2:0]] <= rx_data;
            end
            if (len_q <= `FRAME_MAX) begin
              len_q <= len_q + 9'h001;
            end
            rx_crc_q <= rx_crc_next;
            err_q <= err_q | rx_err;
          end
          if (rx_end) begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          len_q <= 9'h000;
          err_q <= 1'b0;
          rx_crc_q <= `CRC_INIT;
          tx_crc_q <= `CRC_INIT;
          idx_q <= 3'd0;
          half_q <= 1'b0;
          exc_q <= exc;
          is_read_q <= (fc == `FC_READ);
          rd_addr_q <= start;
          left_q <= count[4:0];
          hdr_len_q <= ((exc != `EXC_NONE) || (fc == `FC_READ)) ? 3'd3 : 3'd6;
          if (!discard && (cerr != `CERR_NONE)) begin
            cerr_q <= cerr;
            cerr_pulse_q <= 1'b1;
          end
          if (!discard && (exc == `EXC_NONE) && (fc == `FC_WRITE)) begin
            wr_en_q <= 1'b1;
          end
          if (discard || (q_mem[0] == `BCAST_ADDR)) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_HDR;
          end
        end
        S_HDR: begin
          if (fire) begin
            idx_q <= idx_q + 3'd1;
            if (idx_q + 3'd1 == hdr_len_q) begin
              state_q <= (is_read_q && (exc_q == `EXC_NONE)) ? S_FETCH : S_CRC;
            end
          end
        end
        S_FETCH: begin
          state_q <= S_LATCH;
        end
        S_LATCH: begin
          word_q <= reg_rd_data;
          half_q <= 1'b0;
          state_q <= S_DATA;
        end
        S_DATA: begin
          if (fire) begin
            half_q <= ~half_q;
            if (half_q) begin
              rd_addr_q <= rd_addr_q + 16'h0001;
              left_q <= left_q - 5'd1;
              state_q <= (left_q == 5'd1) ? S_CRC : S_FETCH;
            end
          end
        end
        S_CRC: begin
          if (fire) begin
            half_q <= ~half_q;
            if (half_q) begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign reg_rd_en = ce && (state_q == S_FETCH);
  assign reg_rd_addr = rd_addr_q;
  assign wr_en = wr_en_q;
  assign wr_addr = start;
  assign wr_data = count;
  assign comm_err_code = cerr_q;
  assign comm_err_pulse = cerr_pulse_q;

endmodule // modbus_slave

// ### rtl/modbus_consts.vh
// Constants for the serial slave query checker and read handler.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef MODBUS_CONSTS_VH
`define MODBUS_CONSTS_VH

// ==========================================================
// Function codes, exception flag and broadcast address
`define FC_READ 8'h03
`define FC_WRITE 8'h06
`define FC_DIAG 8'h08
`define FC_WRITE_MULTI 8'h10
`define EXC_FLAG 8'h80
`define BCAST_ADDR 8'h00

// ==========================================================
// Exception codes and communication error codes
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_DATA 8'h03
`define EXC_SLAVE 8'h04
`define CERR_NONE 8'h00
`define CERR_ADDR 8'h88
`define CERR_UI_BUSY 8'h89
`define CERR_NVM_BUSY 8'h8A
`define CERR_RANGE 8'h8C

// ==========================================================
// Limits
`define ADDR_MAX 16'h1FFF
`define ADDR_LIMIT 17'h02000
`define CNT_MAX 16'h0011
`define RD_MAX 16'h0010
`define FIXED_LEN 9'h008
`define MULTI_BASE_LEN 9'h009
`define FRAME_MAX 9'h100
`define FRAME_MIN 9'h004

// ==========================================================
// Frame check
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001

`endif

// ### rtl/crc16_step.v
// One-byte update of the reflected 16-bit frame check.
// Assumes a purely combinational use; the caller holds the register.
`include "modbus_consts.vh"

module crc16_step (
  input wire [15:0] crc_in,
  input wire [7:0] data_in,
  output reg [15:0] crc_out
);

  integer i;

  // ==========================================================
  // Byte update
  // xor, shift, polynomial
  always @* begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[0]) begin
        crc_out = (crc_out >> 1) ^ `CRC_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end

endmodule // crc16_step

// ### rtl/modbus_slave_fix.v
// Holds no logic of its own; the slave and its frame check live beside it.
// Assumes only the shared constants header.
`include "modbus_consts.vh"

// ### verification/modbus_slave_sva.sv
// Checker for the serial slave query checker.
// Assumes ce held high and one byte stream per frame.
module modbus_slave_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_err,
  input wire logic rx_end,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic wr_en,
  input wire logic wr_in_range,
  input wire logic ui_busy,
  input wire logic internal_processing_busy,
  input wire logic nvm_alarm,
  input wire logic [7:0] comm_err_code,
  input wire logic comm_err_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic first_q, bc_q, bad_q, seen_q, rd1_q;
  logic [15:0] last_q;
  logic [7:0] hi_q;
  // ==========================================================
  // Frame tracking
  always @(posedge ref_clk) begin
    rd1_q <= reg_rd_en;
    if (rd1_q) hi_q <= reg_rd_data[15:8];
    if (rst || rx_end) begin
      first_q <= 1'b1;
      bc_q <= 1'b0;
      bad_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (rx_valid) first_q <= 1'b0;
      if (rx_valid && rx_err) bad_q <= 1'b1;
      if (rx_valid && first_q) bc_q <= rx_data == 8'h00;
      if (reg_rd_en) seen_q <= 1'b1;
      if (reg_rd_en) last_q <= reg_rd_addr;
    end
  end
  // ==========================================================
  // Properties
  sequence s_quiet;
    !tx_valid [*6];
  endsequence
  sequence s_hi_out;
    ##[2:3] (tx_valid && tx_data == hi_q);
  endsequence
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  property p_rd_data;
    reg_rd_en |-> s_hi_out;
  endproperty
  property p_rd_asc;
    reg_rd_en && seen_q |-> reg_rd_addr == last_q + 16'h0001;
  endproperty
  property p_ui_busy;
    comm_err_pulse && $past(ui_busy) |=> comm_err_code inside {8'h88, 8'h89, 8'h8C};
  endproperty
  property p_mem_busy;
    comm_err_pulse && !$past(ui_busy) && ($past(nvm_alarm) || $past(internal_processing_busy))
      |=> comm_err_code inside {8'h88, 8'h8A, 8'h8C};
  endproperty
  property p_wr_guard;
    wr_en |-> $past(rx_end, 2) && $past(wr_in_range) && !$past(ui_busy) && !$past(nvm_alarm)
      && !$past(internal_processing_busy);
  endproperty
  property p_bcast_quiet;
    rx_end && bc_q |=> s_quiet;
  endproperty
  property p_bad_quiet;
    rx_end && bad_q |=> s_quiet;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed before taken");
  a_rd_data: assert property (p_rd_data) else $error("register high byte not sent");
  a_rd_asc: assert property (p_rd_asc) else $error("read address not ascending");
  a_ui_busy: assert property (p_ui_busy) else $error("user port busy code wrong");
  a_mem_busy: assert property (p_mem_busy) else $error("internal busy code wrong");
  a_wr_guard: assert property (p_wr_guard) else $error("write while refused");
  a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast answered");
  a_bad_quiet: assert property (p_bad_quiet) else $error("bad frame answered");
endmodule // modbus_slave_sva

bind modbus_slave modbus_slave_sva i_modbus_slave_sva (.ref_clk(ref_clk), .rst(rst),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err), .rx_end(rx_end), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
  .reg_rd_data(reg_rd_data), .wr_en(wr_en), .wr_in_range(wr_in_range), .ui_busy(ui_busy),
  .internal_processing_busy(internal_processing_busy), .nvm_alarm(nvm_alarm),
  .comm_err_code(comm_err_code), .comm_err_pulse(comm_err_pulse));

// ### verification/host_side_model.sv
// Far side model: reply byte sink and holding register store.
// Assumes one clock shared with the slave.
module host_side_model (
  input wire logic ref_clk,
  input wire logic slow,
  output logic tx_ready = 1'b0,
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q = 2'h0;
  // Sink stalls three cycles in four when slow
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 2'h1;
    tx_ready <= !slow || cnt_q == 2'h3;
  end
  // Store answers a cycle after the strobe, then scrambles the bus
  always @(posedge ref_clk) begin
    rd_data <= rd_en ? rd_addr ^ 16'h5A3C : ~rd_data;
  end
endmodule // host_side_model

// ### verification/modbus_slave_read_and_exceptions_tb.sv
// Self-checking bench for the serial slave query checker.
// Assumes the slave under rtl/ and the far side model beside it.
module modbus_slave_read_and_exceptions_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, rx_err = 1'b0, rx_end = 1'b0, slow = 1'b0;
  logic ui_busy = 1'b0, int_busy = 1'b0, nvm = 1'b0, in_range = 1'b1;
  logic [7:0] rx_data = 8'h00, got[$], exp_q[$];
  logic [31:0] seed = 32'h8541, r;
  wire [7:0] tx_data, err_code;
  wire tx_valid, tx_ready, rd_en, wr_en, err_pulse;
  wire [15:0] rd_addr, rd_data, wr_addr, wr_data;
  int error_cnt = 0, compares = 0, cyc = 0, wr_cnt = 0, ep_cnt = 0, cnts[5] = '{1, 2, 16, 17, 0};
  logic [31:0] wr_last = 32'h0000_0000;
  modbus_slave i_modbus_slave (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .slave_addr(8'h11),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err), .rx_end(rx_end), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_rd_en(rd_en), .reg_rd_addr(rd_addr),
    .reg_rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_in_range(in_range), .ui_busy(ui_busy), .internal_processing_busy(int_busy),
    .nvm_alarm(nvm), .comm_err_code(err_code), .comm_err_pulse(err_pulse));
  host_side_model i_host_side_model (.ref_clk(ref_clk), .slow(slow), .tx_ready(tx_ready),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task end_sim();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #25 ref_clk = ~ref_clk;
  // Reply capture, write count and run limit
  always @(posedge ref_clk) begin
    cyc++;
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (err_pulse) ep_cnt++;
    if (wr_en) begin
      wr_cnt++;
      wr_last = {wr_addr, wr_data};
    end
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  // Send one query, model the reply and compare
  task run(input logic [7:0] q[$], input int flt);
    logic [15:0] c, v;
    int a, n, e, ec, w, fc, p;
    c = crc(q);
    q.push_back(c[7:0] ^ {7'h00, flt == 1});
    q.push_back(c[15:8]);
    fc = q[1];
    a = {q[2], q[3]};
    n = {q[4], q[5]};
    e = 0;
    w = wr_cnt;
    p = ep_cnt;
    exp_q = {};
    if (!(fc inside {3, 6, 8, 16}) || fc == 8 && a != 0) e = 1;
    else if (fc != 8 && a > 'h1FFF || fc != 6 && fc != 8 && a + n >= 'h2000) e = 2;
    else if (fc != 6 && fc != 8 && (n == 0 || n > 17 || fc == 3 && n > 16) || fc == 16
      && (q[6] != 2 * n || q.size() != 9 + 2 * n) || fc != 16 && q.size() != 8) e = 3;
    else if (ui_busy || int_busy || nvm || fc == 6 && !in_range) e = 4;
    ec = e == 2 ? 'h88 : e == 3 ? 'h8C : e != 4 ? 0
      : ui_busy ? 'h89 : int_busy || nvm ? 'h8A : 'h8C;
    if (q[0] == 8'h11 && flt == 0) begin
      exp_q = {q[0], q[1]};
      if (e != 0) exp_q = {q[0], q[1] | 8'h80, e[7:0]};
      else if (fc == 3) begin
        exp_q.push_back(q[5] * 8'h02);
        for (int i = 0; i < n; i++) begin
          v = 16'(a + i) ^ 16'h5A3C;
          exp_q.push_back(v[15:8]);
          exp_q.push_back(v[7:0]);
        end
      end else exp_q = q[0:5];
      c = crc(exp_q);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
    got = {};
    foreach (q[i]) begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_err = flt == 2 && i == 3;
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_err = 1'b0;
    rx_end = 1'b1;
    rx_data = ~rx_data;
    @(negedge ref_clk);
    rx_end = 1'b0;
    for (int i = 0; i < 900 && got.size() < exp_q.size(); i++) @(negedge ref_clk);
    repeat (20) @(negedge ref_clk);
    chk("length", got.size(), exp_q.size());
    foreach (exp_q[i]) chk("byte", got[i], exp_q[i]);
    chk("write", wr_cnt - w, e == 0 && fc == 6 && q[0] inside {0, 8'h11} && flt == 0);
    chk("error pulse", ep_cnt - p, ec != 0 && flt == 0 && q[0] inside {0, 8'h11});
    if (wr_cnt - w == 1) chk("write addr", wr_last[31:16], a[15:0]);
    if (wr_cnt - w == 1) chk("write data", wr_last[15:0], n[15:0]);
    if (ec != 0 && flt == 0) chk("error code", err_code, ec);
  endtask
  task rd(input logic [15:0] a, input logic [15:0] n, input int flt);
    run({8'h11, 8'h03, a[15:8], a[7:0], n[15:8], n[7:0]}, flt);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    foreach (cnts[i]) begin
      slow = cnts[i] == 16;
      rd(16'(rnd()) & 16'h0FFF, 16'(cnts[i]), 0);
    end
    slow = 1'b0;
    rd(16'h2000, 16'h0001, 0);
    rd(16'h1FFE, 16'h0002, 0);
    rd(16'h1FFF, 16'h0001, 0);
    run({8'h11, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
    run({8'h11, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 0);
    r = rnd();
    run({8'h11, 8'h08, 8'h00, 8'h00, r[15:8], r[7:0]}, 0);
    run({8'h11, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04}, 0);
    run({8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00}, 0);
    ui_busy = 1'b1;
    rd(16'h0100, 16'h0001, 0);
    rd(16'h2000, 16'h0000, 0);
    ui_busy = 1'b0;
    int_busy = 1'b1;
    rd(16'h0100, 16'h0001, 0);
    int_busy = 1'b0;
    nvm = 1'b1;
    rd(16'h0100, 16'h0001, 0);
    nvm = 1'b0;
    for (int k = 0; k < 3; k++) begin
      in_range = k != 0;
      run({k == 2 ? 8'h00 : 8'h11, 8'h06, 8'h00, 8'h20, 8'h12, 8'h34}, 0);
    end
    rd(16'h0040, 16'h0001, 1);
    rd(16'h0040, 16'h0001, 2);
    run({8'h22, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 0);
    end_sim();
  end
endmodule // modbus_slave_read_and_exceptions_tb
